/* pwr_mode_pkg.sv */
// Constants, register map and state types of the power mode controller.
// Assumes a 40 MHz system clock and 32-bit APB register access.
package pwr_mode_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // Mode register fields
  localparam int MODE_HLCS = 0;
  localparam int MODE_IDLE = 1;
  localparam int MODE_HRDY = 2;
  localparam int MODE_LRDY = 3;
  localparam int MODE_FAST = 4;
  localparam int MODE_DIV = 5;
  localparam logic [7:0] MODE_RESET = 8'h03;

  // Control register fields
  localparam int CTRL_WD_EN = 0;
  localparam int CTRL_OSC = 1;
  localparam int CTRL_KEEP = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int STAT_HALT = 0;
  localparam int STAT_WDX = 1;
  localparam int STAT_MODE = 4;

  // Interrupt bits
  localparam int IRQ_HALT = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_HRDY = 2;
  localparam int IRQ_LRDY = 3;
  localparam int IRQ_W = 4;

  // Oscillator type codes
  localparam logic [1:0] OSC_XTAL = 2'h0;
  localparam logic [1:0] OSC_FAST_RC = 2'h1;
  localparam logic [1:0] OSC_SLOW_RC = 2'h2;

  // Oscillator rates and cycle counts
  localparam int CLK_HZ = 40000000;
  localparam int XTAL_HZ = 8000000;
  localparam int FAST_RC_HZ = 8000000;
  localparam int SLOW_RC_HZ = 32000;
  localparam int XTAL_DIV = CLK_HZ / XTAL_HZ;
  localparam int FAST_RC_DIV = CLK_HZ / FAST_RC_HZ;
  localparam int SLOW_RC_DIV = CLK_HZ / SLOW_RC_HZ;
  localparam logic [10:0] XTAL_STABLE = 11'h400;
  localparam logic [10:0] FAST_RC_STABLE = 11'h010;
  localparam logic [10:0] SLOW_RC_STABLE = 11'h002;
  localparam logic [1:0] SLOW_RC_WAKE = 2'h2;
  localparam logic [2:0] SLOW_DIV_MAX = 3'h1;

  typedef enum logic [2:0] {
    M_RUN, M_STOP_DEEP, M_STOP_WD, M_IDLE_OFF, M_IDLE_ON, M_WAKE, M_FAST
  } mode_e;

  typedef enum logic [1:0] {SRC_NONE, SRC_HIGH, SRC_HDIV, SRC_LOW} src_e;

endpackage

/* osc_tick.sv */
// Oscillator model: one-cycle tick per oscillator period while running.
// Assumes a single system clock; divider restarts whenever the oscillator stops.
`timescale 1ns/10ps
module osc_tick #(
  parameter int DIV = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control and tick
  input wire logic run,
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_s;

  tick_s r, n;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 16'h0000;
    end else if (r.cnt == 16'(DIV - 1)) begin
      n.cnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule

/* pwr_mode_ctrl.sv */
// Operating mode, system clock source and fast wake-up control with APB registers.
// Assumes halt and wake requests come from the core, synchronous to clk.
`timescale 1ns/10ps
module pwr_mode_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core events
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic watchdog_timeout,
  // Clock controls
  output logic [1:0] sys_clk_src,
  output logic [2:0] sys_clk_div,
  output logic high_osc_en,
  output logic low_osc_en,
  output logic high_div_clk_en,
  output logic time_base_en,
  output logic sub_clock_en,
  output logic cpu_run,
  // Watchdog
  output logic watchdog_run,
  output logic watchdog_clear,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic high_low_clock_select;
    logic idle_on_halt_enable;
    logic fast_wake_enable;
    logic [2:0] clock_divider_select;
    logic keep_clock_in_idle;
    logic wd_en;
    logic [1:0] osc_sel;
    logic high_osc_ready_flag;
    logic low_osc_ready_flag;
    logic [10:0] hcnt;
    logic [1:0] lcnt;
    logic [1:0] wcnt;
    pwr_mode_pkg::mode_e mode;
    pwr_mode_pkg::src_e src;
    logic fast_path;
    logic halt_entered_flag;
    logic watchdog_expiry_flag;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic irq;
    logic high_on;
    logic low_on;
    logic tb_en;
    logic cpu_run;
    logic wd_run;
    logic wd_clear;
  } st_s;

  st_s r, n;
  logic [2:0] osc_run;
  logic [2:0] osc_tk;
  localparam int unsigned DIVS [3] = '{
    pwr_mode_pkg::XTAL_DIV, pwr_mode_pkg::FAST_RC_DIV, pwr_mode_pkg::SLOW_RC_DIV
  };

  // Oscillator models: crystal, fast RC, slow RC
  assign osc_run[0] = r.high_on && (r.osc_sel == pwr_mode_pkg::OSC_XTAL);
  assign osc_run[1] = r.high_on && (r.osc_sel == pwr_mode_pkg::OSC_FAST_RC);
  assign osc_run[2] = r.low_on;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_osc
      osc_tick #(.DIV(DIVS[gi])) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(osc_run[gi]),
        .tick(osc_tk[gi])
      );
    end
  endgenerate

  function automatic logic [10:0] stable_ticks(input logic [1:0] sel);
    if (sel == pwr_mode_pkg::OSC_XTAL) begin
      return pwr_mode_pkg::XTAL_STABLE;
    end else if (sel == pwr_mode_pkg::OSC_FAST_RC) begin
      return pwr_mode_pkg::FAST_RC_STABLE;
    end else begin
      return pwr_mode_pkg::SLOW_RC_STABLE;
    end
  endfunction

  always_comb begin
    logic acc;
    logic wr;
    logic high_tick;
    logic slow_sel;
    logic hrdy_rise;
    logic lrdy_rise;
    logic wake_done;
    logic [3:0] ev;
    pwr_mode_pkg::src_e want;
    acc = psel && penable;
    wr = acc && r.pready && pwrite;
    high_tick = 1'b0;
    slow_sel = 1'b0;
    hrdy_rise = 1'b0;
    lrdy_rise = 1'b0;
    wake_done = 1'b0;
    ev = 4'h0;
    want = pwr_mode_pkg::SRC_HIGH;
    n = r;
    n.wd_clear = 1'b0;

    // APB: one wait state, write and read complete together
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (acc && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      unique case (paddr)
        pwr_mode_pkg::ADDR_MODE: begin
          n.prdata[pwr_mode_pkg::MODE_HLCS] = r.high_low_clock_select;
          n.prdata[pwr_mode_pkg::MODE_IDLE] = r.idle_on_halt_enable;
          n.prdata[pwr_mode_pkg::MODE_HRDY] = r.high_osc_ready_flag;
          n.prdata[pwr_mode_pkg::MODE_LRDY] = r.low_osc_ready_flag;
          n.prdata[pwr_mode_pkg::MODE_FAST] = r.fast_wake_enable;
          n.prdata[pwr_mode_pkg::MODE_DIV +: 3] = r.clock_divider_select;
        end
        pwr_mode_pkg::ADDR_CTRL: begin
          n.prdata[pwr_mode_pkg::CTRL_WD_EN] = r.wd_en;
          n.prdata[pwr_mode_pkg::CTRL_OSC +: 2] = r.osc_sel;
          n.prdata[pwr_mode_pkg::CTRL_KEEP] = r.keep_clock_in_idle;
        end
        pwr_mode_pkg::ADDR_STATUS: begin
          n.prdata[pwr_mode_pkg::STAT_HALT] = r.halt_entered_flag;
          n.prdata[pwr_mode_pkg::STAT_WDX] = r.watchdog_expiry_flag;
          n.prdata[pwr_mode_pkg::STAT_MODE +: 3] = r.mode;
        end
        pwr_mode_pkg::ADDR_IRQ_STAT: n.prdata[3:0] = r.irq_st;
        pwr_mode_pkg::ADDR_IRQ_MASK: n.prdata[3:0] = r.irq_mask;
        default: n.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        pwr_mode_pkg::ADDR_MODE: begin
          n.high_low_clock_select = pwdata[pwr_mode_pkg::MODE_HLCS];
          n.idle_on_halt_enable = pwdata[pwr_mode_pkg::MODE_IDLE];
          n.fast_wake_enable = pwdata[pwr_mode_pkg::MODE_FAST];
          n.clock_divider_select = pwdata[pwr_mode_pkg::MODE_DIV +: 3];
        end
        pwr_mode_pkg::ADDR_CTRL: begin
          n.wd_en = pwdata[pwr_mode_pkg::CTRL_WD_EN];
          n.osc_sel = pwdata[pwr_mode_pkg::CTRL_OSC +: 2];
          n.keep_clock_in_idle = pwdata[pwr_mode_pkg::CTRL_KEEP];
        end
        pwr_mode_pkg::ADDR_STATUS: begin
          if (pwdata[pwr_mode_pkg::STAT_HALT]) begin
            n.halt_entered_flag = 1'b0;
          end
          if (pwdata[pwr_mode_pkg::STAT_WDX]) begin
            n.watchdog_expiry_flag = 1'b0;
          end
        end
        pwr_mode_pkg::ADDR_IRQ_STAT: n.irq_st = r.irq_st & ~pwdata[3:0];
        pwr_mode_pkg::ADDR_IRQ_MASK: n.irq_mask = pwdata[3:0];
        default: n.pslverr = 1'b0;
      endcase
    end

    // High oscillator tick in use
    if (r.osc_sel == pwr_mode_pkg::OSC_XTAL) begin
      high_tick = osc_tk[0];
    end else if (r.osc_sel == pwr_mode_pkg::OSC_FAST_RC) begin
      high_tick = osc_tk[1];
    end else begin
      high_tick = osc_tk[2];
    end

    // Stabilisation counters behind the ready flags
    if (!r.high_on) begin
      n.hcnt = 11'h000;
      n.high_osc_ready_flag = 1'b0;
    end else if (!r.high_osc_ready_flag && high_tick) begin
      n.hcnt = r.hcnt + 11'h001;
      if (n.hcnt == stable_ticks(r.osc_sel)) begin
        n.high_osc_ready_flag = 1'b1;
        hrdy_rise = 1'b1;
      end
    end
    if (!r.low_on) begin
      n.lcnt = 2'h0;
      n.low_osc_ready_flag = 1'b0;
    end else if (!r.low_osc_ready_flag && osc_tk[2]) begin
      n.lcnt = r.lcnt + 2'h1;
      if (n.lcnt == pwr_mode_pkg::SLOW_RC_WAKE) begin
        n.low_osc_ready_flag = 1'b1;
        lrdy_rise = 1'b1;
      end
    end

    // Wanted source from select bit and divider field
    slow_sel = !r.high_low_clock_select &&
      (r.clock_divider_select <= pwr_mode_pkg::SLOW_DIV_MAX);
    if (r.high_low_clock_select) begin
      want = pwr_mode_pkg::SRC_HIGH;
    end else if (slow_sel) begin
      want = pwr_mode_pkg::SRC_LOW;
    end else begin
      want = pwr_mode_pkg::SRC_HDIV;
    end

    unique case (r.mode)
      pwr_mode_pkg::M_RUN: begin
        if (halt_req) begin
          ev[pwr_mode_pkg::IRQ_HALT] = 1'b1;
          n.halt_entered_flag = 1'b1;
          n.watchdog_expiry_flag = 1'b0;
          n.wd_clear = 1'b1;
          n.src = pwr_mode_pkg::SRC_NONE;
          if (!r.idle_on_halt_enable && !r.wd_en) begin
            n.mode = pwr_mode_pkg::M_STOP_DEEP;
          end else if (!r.idle_on_halt_enable) begin
            n.mode = pwr_mode_pkg::M_STOP_WD;
          end else if (!r.keep_clock_in_idle) begin
            n.mode = pwr_mode_pkg::M_IDLE_OFF;
          end else begin
            n.mode = pwr_mode_pkg::M_IDLE_ON;
            n.src = r.src;
          end
        end else if (want == pwr_mode_pkg::SRC_LOW) begin
          if (r.low_osc_ready_flag) begin
            n.src = pwr_mode_pkg::SRC_LOW;
          end
        end else if (r.high_osc_ready_flag) begin
          n.src = want;
        end
      end
      pwr_mode_pkg::M_STOP_DEEP, pwr_mode_pkg::M_STOP_WD, pwr_mode_pkg::M_IDLE_OFF: begin
        if (wake_req) begin
          n.mode = pwr_mode_pkg::M_WAKE;
          n.wcnt = 2'h0;
          // Slow RC runs in watchdog stop and clock-off idle but not in deep stop, so deep stop never takes it
          n.fast_path = r.fast_wake_enable && (r.osc_sel == pwr_mode_pkg::OSC_XTAL) &&
            !slow_sel && (r.mode != pwr_mode_pkg::M_STOP_DEEP);
        end
      end
      pwr_mode_pkg::M_IDLE_ON: begin
        if (wake_req) begin
          n.mode = pwr_mode_pkg::M_RUN;
          wake_done = 1'b1;
        end
      end
      pwr_mode_pkg::M_WAKE: begin
        if (r.fast_path) begin
          if (osc_tk[2] && r.wcnt != pwr_mode_pkg::SLOW_RC_WAKE) begin
            n.wcnt = r.wcnt + 2'h1;
          end
          if (r.wcnt == pwr_mode_pkg::SLOW_RC_WAKE) begin
            n.mode = pwr_mode_pkg::M_FAST;
            n.src = pwr_mode_pkg::SRC_LOW;
            wake_done = 1'b1;
          end
        end else if (slow_sel) begin
          if (r.low_osc_ready_flag) begin
            n.mode = pwr_mode_pkg::M_RUN;
            n.src = pwr_mode_pkg::SRC_LOW;
            wake_done = 1'b1;
          end
        end else if (r.high_osc_ready_flag) begin
          n.mode = pwr_mode_pkg::M_RUN;
          n.src = want;
          wake_done = 1'b1;
        end
      end
      pwr_mode_pkg::M_FAST: begin
        if (r.high_osc_ready_flag) begin
          n.mode = pwr_mode_pkg::M_RUN;
          n.src = want;
        end
      end
    endcase
    ev[pwr_mode_pkg::IRQ_WAKE] = wake_done;
    ev[pwr_mode_pkg::IRQ_HRDY] = hrdy_rise;
    ev[pwr_mode_pkg::IRQ_LRDY] = lrdy_rise;

    // Oscillator and clock gating for the next state
    n.high_on = 1'b1;
    if (n.mode == pwr_mode_pkg::M_STOP_DEEP || n.mode == pwr_mode_pkg::M_STOP_WD ||
        n.mode == pwr_mode_pkg::M_IDLE_OFF) begin
      n.high_on = 1'b0;
    end else if (n.mode == pwr_mode_pkg::M_RUN && n.src == pwr_mode_pkg::SRC_LOW &&
                 slow_sel) begin
      n.high_on = 1'b0;
    end
    n.low_on = (n.mode != pwr_mode_pkg::M_STOP_DEEP);
    n.tb_en = (n.mode != pwr_mode_pkg::M_STOP_DEEP) && (n.mode != pwr_mode_pkg::M_STOP_WD);
    n.cpu_run = (n.mode == pwr_mode_pkg::M_RUN) || (n.mode == pwr_mode_pkg::M_FAST);
    n.wd_run = r.wd_en && (n.mode != pwr_mode_pkg::M_STOP_DEEP);

    // Sticky flags: hardware set wins over software clear
    if (watchdog_timeout && r.wd_run) begin
      n.watchdog_expiry_flag = 1'b1;
    end
    n.irq_st = n.irq_st | ev;
    n.irq = |(n.irq_st & n.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.high_low_clock_select <= pwr_mode_pkg::MODE_RESET[pwr_mode_pkg::MODE_HLCS];
      r.idle_on_halt_enable <= pwr_mode_pkg::MODE_RESET[pwr_mode_pkg::MODE_IDLE];
      r.keep_clock_in_idle <= pwr_mode_pkg::CTRL_RESET[pwr_mode_pkg::CTRL_KEEP];
      r.mode <= pwr_mode_pkg::M_RUN;
      r.src <= pwr_mode_pkg::SRC_HIGH;
      r.high_on <= 1'b1;
      r.low_on <= 1'b1;
      r.tb_en <= 1'b1;
      r.cpu_run <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign sys_clk_src = r.src;
  assign sys_clk_div = r.clock_divider_select;
  assign high_osc_en = r.high_on;
  assign low_osc_en = r.low_on;
  assign high_div_clk_en = r.high_on;
  assign time_base_en = r.tb_en;
  assign sub_clock_en = r.low_on;
  assign cpu_run = r.cpu_run;
  assign watchdog_run = r.wd_run;
  assign watchdog_clear = r.wd_clear;
  assign irq = r.irq;

endmodule

/* pwr_mode_ctrl_sva.sv */
// Port assertions for the power mode controller.
// Assumes it is bound to pwr_mode_ctrl; one clock, synchronous reset.
`timescale 1ns/10ps
module pwr_mode_ctrl_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Core and clock controls
  input wire logic halt_req,
  input wire logic [1:0] sys_clk_src,
  input wire logic [2:0] sys_clk_div,
  input wire logic high_osc_en,
  input wire logic low_osc_en,
  input wire logic high_div_clk_en,
  input wire logic time_base_en,
  input wire logic sub_clock_en,
  input wire logic cpu_run,
  input wire logic watchdog_run,
  input wire logic watchdog_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not after one wait state");
  halt_entry_a: assert property (halt_req && cpu_run |=> !cpu_run && watchdog_clear)
    else $error("halt did not stop core and clear watchdog");
  clear_cause_a: assert property (watchdog_clear |-> !cpu_run && $past(halt_req))
    else $error("watchdog clear without halt");
  halt_only_a: assert property ($fell(cpu_run) |-> $past(halt_req))
    else $error("core stopped without halt");
  stop_clock_a: assert property ($fell(cpu_run) && !time_base_en |->
    sys_clk_src == 2'h0 && !high_osc_en)
    else $error("stop left system clock running");
  deep_wd_a: assert property ($fell(cpu_run) && !time_base_en && !$past(watchdog_run) |->
    !watchdog_run && !low_osc_en)
    else $error("deep stop left watchdog or slow oscillator on");
  stop_wd_a: assert property ($fell(cpu_run) && !time_base_en && $past(watchdog_run) |->
    watchdog_run && low_osc_en)
    else $error("watchdog stop lost watchdog clock");
  idle_wd_a: assert property ($fell(cpu_run) && time_base_en && $past(watchdog_run) |->
    watchdog_run)
    else $error("idle stopped an enabled watchdog");
  idle_on_a: assert property ($fell(cpu_run) && sys_clk_src != 2'h0 |->
    time_base_en && sub_clock_en)
    else $error("clock-on idle stopped time base or sub clock");
  slow_stop_a: assert property ($changed(sys_clk_src) && sys_clk_src == 2'h3 &&
    $past(sys_clk_src) != 2'h0 |-> ##[0:2] (!high_osc_en && !high_div_clk_en))
    else $error("high oscillator kept in slow mode");
  div_src_a: assert property ($changed(sys_clk_src) && sys_clk_src == 2'h2 |->
    $past(sys_clk_div) >= 3'h2)
    else $error("divided high clock with slow divider code");
endmodule
bind pwr_mode_ctrl pwr_mode_ctrl_sva chk_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pready(pready), .halt_req(halt_req), .sys_clk_src(sys_clk_src),
  .sys_clk_div(sys_clk_div), .high_osc_en(high_osc_en), .low_osc_en(low_osc_en),
  .high_div_clk_en(high_div_clk_en), .time_base_en(time_base_en),
  .sub_clock_en(sub_clock_en), .cpu_run(cpu_run), .watchdog_run(watchdog_run),
  .watchdog_clear(watchdog_clear));

/* pwr_mode_ctrl_test.sv */
// Self-checking bench for the power mode controller.
// Assumes a 40 MHz clock; bench drives the bus and core events itself.
`timescale 1ns/10ps
module pwr_mode_ctrl_test;
  localparam int XD = pwr_mode_pkg::XTAL_DIV;
  localparam int HD = pwr_mode_pkg::FAST_RC_DIV;
  localparam int LD = pwr_mode_pkg::SLOW_RC_DIV;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic halt_req, wake_req, watchdog_timeout, cpu_run, watchdog_run, watchdog_clear;
  logic high_osc_en, low_osc_en, high_div_clk_en, time_base_en, sub_clock_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] sys_clk_src;
  logic [2:0] sys_clk_div;
  int mismatches, compares, n;
  // Per halt case: mode, control, {fast, clock kept, time base, watchdog}, wake window
  logic [7:0] t_mode [6] = '{8'h11, 8'h11, 8'h03, 8'h03, 8'h11, 8'h11};
  logic [7:0] t_ctrl [6] = '{8'h00, 8'h01, 8'h00, 8'h81, 8'h03, 8'h05};
  logic [3:0] t_exp [6] = '{4'b0000, 4'b1001, 4'b0010, 4'b0111, 4'b0001, 4'b0001};
  int t_lo [6] = '{1023 * XD, LD, 1023 * XD, 0, 15 * HD, LD};
  int t_hi [6] = '{1025 * XD + 5, 2 * LD + 5, 1025 * XD + 5, 2, 16 * HD + 5, 2 * LD + 5};

  pwr_mode_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req),
    .watchdog_timeout(watchdog_timeout), .sys_clk_src(sys_clk_src),
    .sys_clk_div(sys_clk_div), .high_osc_en(high_osc_en), .low_osc_en(low_osc_en),
    .high_div_clk_en(high_div_clk_en), .time_base_en(time_base_en),
    .sub_clock_en(sub_clock_en), .cpu_run(cpu_run), .watchdog_run(watchdog_run),
    .watchdog_clear(watchdog_clear), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Whole bus transfer; data checked only on reads expected to succeed
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk({31'h0, pready}, 32'h1);
    if (!w && !err) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_src(input logic [1:0] s, input int lim);
    int k;
    k = 0;
    while (sys_clk_src !== s && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk({30'h0, sys_clk_src}, {30'h0, s});
  endtask

  task automatic irq_is(input logic v);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, v});
  endtask

  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard; the tests need about 25k cycles
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial begin
    {sys_rst, psel, penable, pwrite, halt_req, wake_req, watchdog_timeout} = 7'h40;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (1030 * XD) @(posedge clk);
    apb(pwr_mode_pkg::ADDR_MODE, 1'b0, 32'h0, 32'h0F, 1'b0);
    apb(pwr_mode_pkg::ADDR_CTRL, 1'b0, 32'h0, 32'h00, 1'b0);
    apb(8'h14, 1'b0, 32'h0, 32'h0, 1'b1);
    apb(pwr_mode_pkg::ADDR_MODE, 1'b1, 32'h01, 32'h0, 1'b0);
    apb(pwr_mode_pkg::ADDR_MODE, 1'b0, 32'h0, 32'h0D, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      apb(pwr_mode_pkg::ADDR_MODE, 1'b1, {24'h0, t_mode[i]}, 32'h0, 1'b0);
      apb(pwr_mode_pkg::ADDR_CTRL, 1'b1, {24'h0, t_ctrl[i]}, 32'h0, 1'b0);
      @(posedge clk);
      watchdog_timeout <= 1'b1;
      @(posedge clk);
      watchdog_timeout <= 1'b0;
      apb(pwr_mode_pkg::ADDR_STATUS, 1'b0, 32'h0, {30'h0, t_exp[i][0], 1'b0}, 1'b0);
      @(posedge clk);
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      #1;
      chk({31'h0, cpu_run}, 32'h0);
      chk({29'h0, time_base_en, watchdog_run, sys_clk_src != 2'h0},
          {29'h0, t_exp[i][1:0], t_exp[i][2]});
      @(posedge clk);
      wake_req <= 1'b1;
      n = 0;
      while (cpu_run !== 1'b1 && n < 8000) begin
        @(posedge clk);
        n++;
      end
      wake_req <= 1'b0;
      chk({31'h0, n >= t_lo[i] && n <= t_hi[i]}, 32'h1);
      chk({30'h0, sys_clk_src}, t_exp[i][3] ? 32'h3 : 32'h1);
      wait_src(2'h1, 1100 * XD);
      apb(pwr_mode_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h01, 1'b0);
      apb(pwr_mode_pkg::ADDR_STATUS, 1'b1, 32'h03, 32'h0, 1'b0);
      $display("test halt case %0d done", i);
    end
    apb(pwr_mode_pkg::ADDR_MODE, 1'b1, 32'h20, 32'h0, 1'b0);
    wait_src(2'h3, 100);
    chk({30'h0, high_osc_en, high_div_clk_en}, 32'h0);
    apb(pwr_mode_pkg::ADDR_MODE, 1'b1, 32'h40, 32'h0, 1'b0);
    wait_src(2'h2, 1100 * XD);
    chk({29'h0, sys_clk_div}, 32'h2);
    apb(pwr_mode_pkg::ADDR_MODE, 1'b1, 32'h01, 32'h0, 1'b0);
    wait_src(2'h1, 100);
    $display("test slow mode done");
    apb(pwr_mode_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0, 32'h0F, 1'b0);
    apb(pwr_mode_pkg::ADDR_IRQ_MASK, 1'b1, 32'h02, 32'h0, 1'b0);
    irq_is(1'b1);
    apb(pwr_mode_pkg::ADDR_IRQ_MASK, 1'b1, 32'h00, 32'h0, 1'b0);
    irq_is(1'b0);
    apb(pwr_mode_pkg::ADDR_IRQ_MASK, 1'b1, 32'h02, 32'h0, 1'b0);
    apb(pwr_mode_pkg::ADDR_IRQ_STAT, 1'b1, 32'h02, 32'h0, 1'b0);
    irq_is(1'b0);
    apb(pwr_mode_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0, 32'h0D, 1'b0);
    $display("test interrupt done");
    summarize();
  end
endmodule
